// ===== src/sgcr_pkg.sv
// constants and types for the serial gain control register
// Function
// RULE1 - gain code maps linearly: code 0 is +20 dB, code 63 is -11.5 dB
// RULE2 - each transaction is one 16-bit word while a channel select is low
// RULE3 - a word with write flag 0 stores the six gain code bits
// RULE4 - a write also stores the two fast attack step selector bits
// RULE5 - unused bits of every received word have no effect at all
// RULE6 - a word with write flag 1 leaves stored gain and step unchanged
// RULE7 - the transaction after a read request shifts the stored word out
// RULE8 - after a readback the channel returns to write mode by itself
// RULE9 - controller sends a read word, then releases data and clocks 16 more
// RULE10 - each channel powers down while its own power-up input is low
// RULE11 - basic gain resolution is 0.5 dB per code step
// RULE12 - each channel holds its own code, set only by the selected interface
// RULE13 - interface select 00 parallel, 01 serial, 10 or 11 up/down
// RULE14 - both selects low writes identical data into both channels
// RULE15 - fast trigger high lowers gain by 2, 4, 8 or 16 dB
// RULE16 - fast attack reduction saturates at code 63 instead of wrapping
// RULE17 - data pin stays released except while shifting out a readback word
package sgcr_pkg;
  localparam int          WORD_BITS      = 16;
  localparam int          RW_POS         = 15;
  localparam int          FAST_HI_POS    = 7;
  localparam int          FAST_LO_POS    = 6;
  localparam int          GAIN_MSB       = 5;
  localparam logic [4:0]  BIT_COUNT_LAST = 5'h0F;
  localparam logic [4:0]  BIT_COUNT_FULL = 5'h10;
  localparam logic [5:0]  GAIN_RESET     = 6'h3F;
  localparam logic [5:0]  GAIN_MAX_CODE  = 6'h3F;
  localparam logic [1:0]  FAST_SEL_RESET = 2'h0;
  localparam logic [1:0]  IFACE_SERIAL   = 2'h1;
  localparam logic [1:0]  SEL_NONE_N     = 2'h3;
  localparam logic [6:0]  FAST_STEP_BASE = 7'h04; // 2 dB in half-dB codes
  localparam logic [6:0]  GAIN_TOP_HDB   = 7'h28; // +20 dB in half dB
  localparam logic [6:0]  GAIN_CODE_LIM  = 7'h3F;
  localparam logic [6:0]  UNUSED_FILL    = 7'h00;

  // pins seen through the synchroniser
  typedef struct packed {
    logic       sclk;
    logic       sdio;
    logic [1:0] sel_n;
    logic [1:0] fast;
    logic [1:0] pwr_up;
    logic [1:0] iface;
  } sgcr_pins_t;

  // stored per channel setting
  typedef struct packed {
    logic [1:0] fast_sel;
    logic [5:0] gain;
  } sgcr_cfg_t;

  typedef enum logic [1:0] {
    SGCR_IDLE,
    SGCR_WRITE,
    SGCR_READ,
    SGCR_SKIP
  } sgcr_phase_t;

  // channel output stage state
  typedef struct packed {
    logic [5:0] code;
    logic [6:0] hdb;
    logic       pd;
  } sgcr_chan_st_t;

  // serial engine state
  typedef struct packed {
    sgcr_pins_t      meta;
    sgcr_pins_t      pins;
    logic            sclk_prev;
    sgcr_phase_t     phase;
    logic [1:0]      sel;
    logic [15:0]     shift;
    logic [4:0]      count;
    logic [1:0]      rd_pending;
    sgcr_cfg_t [1:0] cfg;
    logic            sdio_out;
    logic            sdio_oe_n;
  } sgcr_state_t;
endpackage : sgcr_pkg

// ===== src/sgcr_chan.sv
// per channel gain mapping, fast attack and power down
`timescale 1ns/1ps
`default_nettype none
module sgcr_chan (
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  input  wire sgcr_pkg::sgcr_cfg_t i_cfg,
  input  wire logic              i_fast,
  input  wire logic              i_power_up,
  output logic [5:0]             o_eff_code,
  output logic [6:0]             o_gain_hdb,
  output logic                   o_power_down
);
  sgcr_pkg::sgcr_chan_st_t st;
  sgcr_pkg::sgcr_chan_st_t next_st;
  logic [6:0]              step;
  logic [6:0]              sum;

  ////////////////////////////////////////////////////////////////////////////
  // effective code and gain
  always_comb begin
    next_st = st;
    step    = 7'(sgcr_pkg::FAST_STEP_BASE << i_cfg.fast_sel);
    sum     = {1'b0, i_cfg.gain} + step;
    // RULE15 fast attack step
    if (i_fast) begin
      // RULE16 saturate at minimum gain
      if (sum > sgcr_pkg::GAIN_CODE_LIM) begin
        next_st.code = sgcr_pkg::GAIN_MAX_CODE;
      end else begin
        next_st.code = sum[5:0];
      end
    end else begin
      // RULE11 half dB per code
      next_st.code = i_cfg.gain;
    end
    // RULE1 linear gain map
    next_st.hdb = sgcr_pkg::GAIN_TOP_HDB - {1'b0, next_st.code};
    // RULE10 independent power down
    next_st.pd  = ~i_power_up;
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st      <= '0;
      st.code <= sgcr_pkg::GAIN_RESET;
      st.hdb  <= sgcr_pkg::GAIN_TOP_HDB - {1'b0, sgcr_pkg::GAIN_RESET};
      st.pd   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_eff_code   = st.code;
  assign o_gain_hdb   = st.hdb;
  assign o_power_down = st.pd;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_gain_map;
    @(posedge i_clk) disable iff (!i_reset_n)
    $signed(o_gain_hdb) == 7'sd40 - $signed({1'b0, o_eff_code});
  endproperty
  a_gain_map: assert property (p_gain_map) // RULE1
    else $error("gain does not follow code");

  property p_fast_step;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_fast && (sum <= 7'h3F) |=> o_eff_code == $past(sum[5:0]);
  endproperty
  a_fast_step: assert property (p_fast_step) // RULE15
    else $error("fast attack step wrong");

  property p_fast_sat;
    @(posedge i_clk) disable iff (!i_reset_n)
    i_fast && (i_cfg.gain + (7'h04 << i_cfg.fast_sel) > 7'h3F)
      |=> o_eff_code == 6'h3F;
  endproperty
  a_fast_sat: assert property (p_fast_sat) // RULE16
    else $error("fast attack did not saturate");

  property p_plain_code;
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_fast |=> o_eff_code == $past(i_cfg.gain);
  endproperty
  a_plain_code: assert property (p_plain_code) // RULE11
    else $error("code differs from stored gain");

  property p_power_down;
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_power_up |=> o_power_down ##0 o_eff_code == $past(i_cfg.gain) ||
      $past(i_fast);
  endproperty
  a_power_down: assert property (p_power_down) // RULE10
    else $error("power down missing");

  c_fast: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    i_fast && i_cfg.fast_sel == 2'h3);
endmodule : sgcr_chan
`default_nettype wire

// ===== src/sgcr_top.sv
// serial gain word engine for two channels
`timescale 1ns/1ps
`default_nettype none
module sgcr_top (
  input  wire logic   i_clk,
  input  wire logic   i_reset_n,
  input  wire logic   i_sclk,
  input  wire logic   i_sdio,
  input  wire logic   i_chan_a_select_n,
  input  wire logic   i_chan_b_select_n,
  input  wire logic   i_chan_a_fast_trigger,
  input  wire logic   i_chan_b_fast_trigger,
  input  wire logic   i_chan_a_power_up,
  input  wire logic   i_chan_b_power_up,
  input  wire logic   i_iface_sel_lo,
  input  wire logic   i_iface_sel_hi,
  output logic        o_sdio_out,
  output logic        o_sdio_oe_n,
  output logic [11:0] o_stored_code,
  output logic [3:0]  o_fast_step_sel,
  output logic [11:0] o_eff_code,
  output logic [13:0] o_gain_hdb,
  output logic [1:0]  o_power_down
);
  sgcr_pkg::sgcr_state_t st;
  sgcr_pkg::sgcr_state_t next_st;
  sgcr_pkg::sgcr_pins_t  raw;
  logic                  bit_rise;
  logic                  bit_fall;
  logic                  sel_idle;
  logic                  word_done;
  logic                  rd_done;
  logic                  rd_ch;
  logic [15:0]           next_word;
  logic [15:0]           rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // pin bundle
  always_comb begin
    raw.sclk   = i_sclk;
    raw.sdio   = i_sdio;
    raw.sel_n  = {i_chan_b_select_n, i_chan_a_select_n};
    raw.fast   = {i_chan_b_fast_trigger, i_chan_a_fast_trigger};
    raw.pwr_up = {i_chan_b_power_up, i_chan_a_power_up};
    raw.iface  = {i_iface_sel_hi, i_iface_sel_lo};
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial engine
  always_comb begin
    next_st           = st;
    next_st.meta      = raw;
    next_st.pins      = st.meta;
    next_st.sclk_prev = st.pins.sclk;
    bit_rise  = st.pins.sclk & ~st.sclk_prev;
    bit_fall  = ~st.pins.sclk & st.sclk_prev;
    sel_idle  = (st.pins.sel_n == sgcr_pkg::SEL_NONE_N);
    next_word = {st.shift[14:0], st.pins.sdio};
    word_done = 1'b0;
    rd_done   = 1'b0;
    rd_ch     = ~st.sel[0];
    rd_word   = 16'h0000;
    unique case (st.phase)
      sgcr_pkg::SGCR_IDLE: begin
        // RULE12 serial only when selected
        if (!sel_idle && st.pins.iface == sgcr_pkg::IFACE_SERIAL) begin
          next_st.sel   = ~st.pins.sel_n;
          next_st.count = 5'h00;
          rd_ch         = st.pins.sel_n[0];
          rd_word       = {1'b0, sgcr_pkg::UNUSED_FILL, st.cfg[rd_ch]};
          // RULE7 readback follows request
          if (st.rd_pending[rd_ch]) begin
            next_st.phase     = sgcr_pkg::SGCR_READ;
            next_st.shift     = rd_word;
            next_st.sdio_out  = rd_word[sgcr_pkg::RW_POS];
            next_st.sdio_oe_n = 1'b0;
          end else begin
            next_st.phase = sgcr_pkg::SGCR_WRITE;
          end
        end
      end
      sgcr_pkg::SGCR_WRITE: begin
        if (sel_idle) begin
          next_st.phase = sgcr_pkg::SGCR_IDLE; // short word dropped
        end else if (bit_rise) begin
          // RULE2 sixteen bit word
          next_st.shift = next_word;
          next_st.count = st.count + 5'h01;
          if (st.count == sgcr_pkg::BIT_COUNT_LAST) begin
            word_done     = 1'b1;
            next_st.phase = sgcr_pkg::SGCR_SKIP;
          end
        end
      end
      sgcr_pkg::SGCR_READ: begin
        if (sel_idle) begin
          next_st.phase     = sgcr_pkg::SGCR_IDLE;
          next_st.sdio_oe_n = 1'b1;
        end else if (bit_rise) begin
          next_st.count = st.count + 5'h01;
          if (st.count == sgcr_pkg::BIT_COUNT_LAST) begin
            // RULE8 back to write mode
            rd_done                    = 1'b1;
            next_st.rd_pending[rd_ch]  = 1'b0;
            next_st.phase              = sgcr_pkg::SGCR_SKIP;
            // RULE17 release after last bit
            next_st.sdio_oe_n          = 1'b1;
          end
        end else if (bit_fall) begin
          next_st.shift    = {st.shift[14:0], 1'b0};
          next_st.sdio_out = st.shift[14];
        end
      end
      sgcr_pkg::SGCR_SKIP: begin
        // extra clocks ignored until release
        if (sel_idle) begin
          next_st.phase = sgcr_pkg::SGCR_IDLE;
        end
      end
    endcase
    // RULE14 commit per selected channel
    for (int i = 0; i < 2; i++) begin
      if (word_done && st.sel[i]) begin
        if (next_word[sgcr_pkg::RW_POS]) begin
          // RULE6 read request only
          next_st.rd_pending[i] = 1'b1;
        end else begin
          // RULE3 gain bits; RULE5 unused bits dropped
          next_st.cfg[i].gain     = next_word[sgcr_pkg::GAIN_MSB:0];
          // RULE4 fast step selector
          next_st.cfg[i].fast_sel = {next_word[sgcr_pkg::FAST_HI_POS],
                                     next_word[sgcr_pkg::FAST_LO_POS]};
        end
      end
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st                  <= '0;
      st.meta.sel_n       <= sgcr_pkg::SEL_NONE_N;
      st.pins.sel_n       <= sgcr_pkg::SEL_NONE_N;
      st.phase            <= sgcr_pkg::SGCR_IDLE;
      st.cfg[0].gain      <= sgcr_pkg::GAIN_RESET;
      st.cfg[1].gain      <= sgcr_pkg::GAIN_RESET;
      st.cfg[0].fast_sel  <= sgcr_pkg::FAST_SEL_RESET;
      st.cfg[1].fast_sel  <= sgcr_pkg::FAST_SEL_RESET;
      st.sdio_oe_n        <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_sdio_out      = st.sdio_out;
  assign o_sdio_oe_n     = st.sdio_oe_n;
  assign o_stored_code   = {st.cfg[1].gain, st.cfg[0].gain};
  assign o_fast_step_sel = {st.cfg[1].fast_sel, st.cfg[0].fast_sel};

  ////////////////////////////////////////////////////////////////////////////
  // channel output stages
  for (genvar g = 0; g < 2; g++) begin : g_chan
    sgcr_chan u_chan (
      .i_clk        (i_clk),
      .i_reset_n    (i_reset_n),
      .i_cfg        (st.cfg[g]),
      .i_fast       (st.pins.fast[g]),
      .i_power_up   (st.pins.pwr_up[g]),
      .o_eff_code   (o_eff_code[g*6 +: 6]),
      .o_gain_hdb   (o_gain_hdb[g*7 +: 7]),
      .o_power_down (o_power_down[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // count never passes one word
  property p_word_len;
    @(posedge i_clk) disable iff (!i_reset_n)
    st.count <= sgcr_pkg::BIT_COUNT_FULL;
  endproperty
  a_word_len: assert property (p_word_len) // RULE2
    else $error("bit count beyond word");

  // written gain lands in channel a
  property p_write_gain;
    @(posedge i_clk) disable iff (!i_reset_n)
    word_done && !next_word[15] && st.sel[0]
      |=> st.cfg[0].gain == $past(next_word[5:0]);
  endproperty
  a_write_gain: assert property (p_write_gain) // RULE3
    else $error("gain code not stored");

  // written step lands in channel b
  property p_write_step;
    @(posedge i_clk) disable iff (!i_reset_n)
    word_done && !next_word[15] && st.sel[1]
      |=> st.cfg[1].fast_sel == $past(next_word[7:6]);
  endproperty
  a_write_step: assert property (p_write_step) // RULE4
    else $error("fast step not stored");

  // only the low byte is kept
  property p_unused;
    @(posedge i_clk) disable iff (!i_reset_n)
    word_done && !next_word[15] && st.sel[1]
      |=> st.cfg[1] == $past(next_word[7:0]);
  endproperty
  a_unused: assert property (p_unused) // RULE5
    else $error("unused bits leaked");

  // read request keeps settings, marks channels
  property p_read_keep;
    @(posedge i_clk) disable iff (!i_reset_n)
    word_done && next_word[15] |=> st.cfg == $past(st.cfg) ##0
      (st.rd_pending & $past(st.sel)) == $past(st.sel);
  endproperty
  a_read_keep: assert property (p_read_keep) // RULE6
    else $error("read word altered setting");

  // readback starts with the pin driven
  property p_read_drive;
    @(posedge i_clk) disable iff (!i_reset_n)
    st.phase == sgcr_pkg::SGCR_IDLE ##1 st.phase == sgcr_pkg::SGCR_READ
      |-> !st.sdio_oe_n && $past(st.rd_pending) != 2'h0;
  endproperty
  a_read_drive: assert property (p_read_drive) // RULE7
    else $error("readback not driven");

  // full readback clears the pending read
  property p_read_clear;
    @(posedge i_clk) disable iff (!i_reset_n)
    rd_done |=> !st.rd_pending[$past(rd_ch)] && st.sdio_oe_n;
  endproperty
  a_read_clear: assert property (p_read_clear) // RULE8
    else $error("read state not cleared");

  // other interface modes never start a word
  property p_iface_gate;
    @(posedge i_clk) disable iff (!i_reset_n)
    st.phase == sgcr_pkg::SGCR_IDLE && st.pins.iface != 2'h1
      |=> st.phase == sgcr_pkg::SGCR_IDLE;
  endproperty
  a_iface_gate: assert property (p_iface_gate) // RULE12
    else $error("serial active in other mode");

  // joint write gives equal channels
  property p_both;
    @(posedge i_clk) disable iff (!i_reset_n)
    word_done && !next_word[15] && st.sel == 2'h3
      |=> st.cfg[0] == st.cfg[1];
  endproperty
  a_both: assert property (p_both) // RULE14
    else $error("channels differ after joint write");

  // pin released outside readback
  property p_release;
    @(posedge i_clk) disable iff (!i_reset_n)
    st.phase != sgcr_pkg::SGCR_READ |-> st.sdio_oe_n;
  endproperty
  a_release: assert property (p_release) // RULE17
    else $error("data pin driven outside readback");

  // cut word leaves settings alone
  property p_short_drop;
    @(posedge i_clk) disable iff (!i_reset_n)
    st.phase == sgcr_pkg::SGCR_WRITE && sel_idle
      |=> st.phase == sgcr_pkg::SGCR_IDLE && st.cfg == $past(st.cfg);
  endproperty
  a_short_drop: assert property (p_short_drop) // RULE2
    else $error("short word not dropped");

  // extra clocks after a word are ignored
  property p_skip_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
    st.phase == sgcr_pkg::SGCR_SKIP && !sel_idle
      |=> st.phase == sgcr_pkg::SGCR_SKIP && st.cfg == $past(st.cfg);
  endproperty
  a_skip_hold: assert property (p_skip_hold) // RULE2
    else $error("clocks after word changed state");

  // next readback bit after each falling clock
  property p_read_shift;
    @(posedge i_clk) disable iff (!i_reset_n)
    st.phase == sgcr_pkg::SGCR_READ && !sel_idle && bit_fall
      |=> st.sdio_out == $past(st.shift[14]);
  endproperty
  a_read_shift: assert property (p_read_shift) // RULE7
    else $error("readback bit not shifted");

  // pending reads move only at word ends
  property p_pend_keep;
    @(posedge i_clk) disable iff (!i_reset_n)
    !word_done && !rd_done |=> st.rd_pending == $past(st.rd_pending);
  endproperty
  a_pend_keep: assert property (p_pend_keep) // RULE8
    else $error("read state changed mid word");

  c_write: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    word_done && !next_word[15]);
  c_read_req: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    word_done && next_word[15]);
  c_read_done: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    rd_done);
  c_both: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    word_done && st.sel == 2'h3);
endmodule : sgcr_top
`default_nettype wire

// ===== testbench/sgcr_ctrl_model.sv
// controller model driving the serial gain link
`timescale 1ns/1ps
`default_nettype none
module sgcr_ctrl_model (
  input  wire logic       i_sdio,
  output logic            o_sclk,
  output logic            o_sdio,
  output logic            o_sdio_oe_n,
  output logic [1:0]      o_select_n
);
  // link idle: clock low, data released, no channel selected
  initial begin
    o_sclk = 1'b0;
    o_sdio = 1'b0;
    o_sdio_oe_n = 1'b1;
    o_select_n = 2'h3;
  end

  // one framed word, msb first; half sets the clock pace
  task automatic xfer(input logic [1:0] sel_n, input logic [15:0] word,
                      input int nbits, input bit rd, input int half,
                      output logic [15:0] rdata);
    rdata = 16'h0000;
    o_select_n = sel_n;
    #(half);
    for (int i = 15; i > 15 - nbits; i--) begin
      o_sdio_oe_n = rd;
      o_sdio = word[i];
      #(half);
      rdata[i] = i_sdio; // sample at the rising edge
      o_sclk = 1'b1;
      #(half);
      o_sclk = 1'b0;
    end
    #(half);
    o_sdio_oe_n = 1'b1;
    o_select_n = 2'h3;
    #300;
  endtask : xfer
endmodule : sgcr_ctrl_model
`default_nettype wire

// ===== testbench/sgcr_top_test.sv
// self-checking bench for the serial gain word engine
`timescale 1ns/1ps
`default_nettype none
module sgcr_top_test;
  logic        clk;
  logic        reset_n;
  logic        sclk;
  logic        sdio;
  logic        ctl_sdio;
  logic        ctl_oe_n;
  logic [1:0]  sel_n;
  logic [1:0]  fast;
  logic [1:0]  pwr;
  logic [1:0]  iface;
  logic        flt = 1'b0;
  logic        dut_sdio;
  logic        dut_oe_n;
  logic [11:0] stored;
  logic [3:0]  step;
  logic [11:0] eff;
  logic [13:0] hdb;
  logic [1:0]  pd;
  logic [15:0] rd;
  int          errors;
  int          checked;

  // wire level; a released line toggles every cycle
  assign sdio = !dut_oe_n ? dut_sdio : !ctl_oe_n ? ctl_sdio : flt;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) flt <= ~flt;

  sgcr_top i_sgcr_top (
    .i_clk                 (clk),
    .i_reset_n             (reset_n),
    .i_sclk                (sclk),
    .i_sdio                (sdio),
    .i_chan_a_select_n     (sel_n[0]),
    .i_chan_b_select_n     (sel_n[1]),
    .i_chan_a_fast_trigger (fast[0]),
    .i_chan_b_fast_trigger (fast[1]),
    .i_chan_a_power_up     (pwr[0]),
    .i_chan_b_power_up     (pwr[1]),
    .i_iface_sel_lo        (iface[0]),
    .i_iface_sel_hi        (iface[1]),
    .o_sdio_out            (dut_sdio),
    .o_sdio_oe_n           (dut_oe_n),
    .o_stored_code         (stored),
    .o_fast_step_sel       (step),
    .o_eff_code            (eff),
    .o_gain_hdb            (hdb),
    .o_power_down          (pd)
  );

  sgcr_ctrl_model i_sgcr_ctrl_model (
    .i_sdio      (sdio),
    .o_sclk      (sclk),
    .o_sdio      (ctl_sdio),
    .o_sdio_oe_n (ctl_oe_n),
    .o_select_n  (sel_n)
  );

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] s, input logic [15:0] w, input int h);
    i_sgcr_ctrl_model.xfer(s, w, 16, 1'b0, h, rd);
    repeat (4) @(negedge clk);
  endtask : wr

  task automatic settle();
    repeat (8) @(negedge clk);
  endtask : settle

  task automatic conclude();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // write with unused bits set, then channel b alone at slow pace
  task automatic t_write();
    wr(2'h2, 16'h7FC0, 100);
    chk(16'(stored), 16'hFC0);
    chk(16'(step), 16'h3);
    chk(16'(hdb[6:0]), 16'h28);
    chk(16'(dut_oe_n), 16'h1);
    wr(2'h1, 16'h0055, 300);
    chk(16'(stored), 16'h540);
    chk(16'(step), 16'h7);
  endtask : t_write

  // both selects, gain map at the ends and middle
  task automatic t_map();
    logic [5:0] c;
    logic [6:0] h;
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 6'h00 : (i == 1) ? 6'h01 : (i == 2) ? 6'h20 : 6'h3F;
      h = 7'(8'h28 - 8'(c));
      wr(2'h0, {10'h000, c}, 100);
      settle();
      chk(16'(stored), 16'({c, c}));
      chk(16'(hdb), 16'({h, h}));
      chk(16'(eff), 16'({c, c}));
    end
  endtask : t_map

  // read request then readback, then a plain write
  task automatic t_read();
    wr(2'h2, 16'h0085, 100);
    wr(2'h2, 16'h807A, 100);
    chk(16'(stored[5:0]), 16'h05);
    chk(16'(step[1:0]), 16'h2);
    i_sgcr_ctrl_model.xfer(2'h2, 16'h0000, 16, 1'b1, 100, rd);
    chk(rd, 16'h0085);
    chk(16'(dut_oe_n), 16'h1);
    wr(2'h2, 16'h000A, 100);
    chk(16'(stored[5:0]), 16'h0A);
    wr(2'h1, 16'h8000, 100);
    i_sgcr_ctrl_model.xfer(2'h1, 16'h0000, 16, 1'b1, 100, rd);
    chk(rd, 16'h003F);
  endtask : t_read

  // every step selector with the trigger held
  task automatic t_fast();
    logic [6:0] e;
    for (int s = 0; s < 4; s++) begin
      e = 7'h28 + (7'h04 << s);
      wr(2'h2, 16'(s * 64 + 40), 100);
      fast = 2'h3;
      settle();
      chk(16'(eff[5:0]), (e > 7'h3F) ? 16'h3F : 16'(e));
      chk(16'(eff[11:6]), 16'h3F);
      chk(16'(stored[5:0]), 16'h28);
      fast = 2'h0;
      settle();
      chk(16'(eff[5:0]), 16'h28);
    end
  endtask : t_fast

  // short word and wrong interface both leave state alone
  task automatic t_refuse();
    i_sgcr_ctrl_model.xfer(2'h2, 16'h0001, 8, 1'b0, 100, rd);
    chk(16'(stored[5:0]), 16'h28);
    iface = 2'h0;
    wr(2'h2, 16'h0002, 100);
    chk(16'(stored[5:0]), 16'h28);
    iface = 2'h3;
    wr(2'h2, 16'h0002, 100);
    chk(16'(stored[5:0]), 16'h28);
    @(negedge clk) iface = 2'h1;
  endtask : t_refuse

  // power-up inputs per channel
  task automatic t_power();
    pwr = 2'h2;
    settle();
    chk(16'(pd), 16'h1);
    pwr = 2'h1;
    settle();
    chk(16'(pd), 16'h2);
    pwr = 2'h3;
    settle();
    chk(16'(pd), 16'h0);
  endtask : t_power

  ////////////////////////////////////////////////////////////
  initial begin
    errors = 0;
    checked = 0;
    reset_n = 1'b0;
    fast = 2'h0;
    pwr = 2'h3;
    iface = 2'h1;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    settle();
    chk(16'(stored), 16'hFFF);
    chk(16'(pd), 16'h0);
    t_write();
    t_map();
    t_read();
    t_fast();
    t_refuse();
    t_power();
    conclude();
  end

  // watchdog well beyond the expected run
  initial begin
    #400000;
    errors++;
    conclude();
  end
endmodule : sgcr_top_test
`default_nettype wire
